// ==== hw/siu_pkg.sv ====
// Constants shared by the subtract instruction unit.
package siu_pkg;
   // Register byte offsets on the APB.
   localparam logic [7:0] SIU_OFS_INSTR = 8'h00;
   localparam logic [7:0] SIU_OFS_ACC = 8'h04;
   localparam logic [7:0] SIU_OFS_STATUS = 8'h08;
   localparam logic [7:0] SIU_OFS_PTR = 8'h0C;
   localparam logic [7:0] SIU_OFS_DATA = 8'h10;
   // Widths of the bus and the datapath.
   localparam int SIU_AW = 8;
   localparam int SIU_DW = 32;
   localparam int SIU_OPW = 14;
   localparam int SIU_FAW = 7;
   localparam int SIU_FILE_DEPTH = 128;
   // Status register bit positions.
   localparam int SIU_BIT_C = 0;
   localparam int SIU_BIT_NIB = 1;
   localparam int SIU_BIT_Z = 2;
   // Opcode fields: literal form is 11 110x kkkk kkkk, file form 00 0010 dfff ffff.
   localparam logic [4:0] SIU_OPC_LIT = 5'h1E;
   localparam int SIU_OPC_LIT_LSB = 9;
   localparam logic [5:0] SIU_OPC_REG = 6'h02;
   localparam int SIU_OPC_REG_LSB = 8;
   localparam int SIU_DEST_BIT = 7;
   // Values after reset.
   localparam logic [7:0] SIU_ACC_RST = 8'h00;
   localparam logic [13:0] SIU_OP_RST = 14'h0000;
   localparam logic [6:0] SIU_PTR_RST = 7'h00;
   localparam logic SIU_FLAG_RST = 1'b0;
endpackage

// ==== hw/siu_sub.sv ====
// Eight-bit two's complement subtractor with borrow and zero flags.
`timescale 1ns/100ps
module siu_sub
(
   // Operands.
   input wire logic [7:0] minuend,
   input wire logic [7:0] subtrahend,
   // Result and flags.
   output logic [7:0] diff,
   output logic no_borrow,
   output logic nibble_no_borrow,
   output logic is_zero
);
   logic [8:0] full;
   logic [4:0] low;

   // The ninth bit of the widened difference is the borrow out.
   always_comb
   begin
      full = {1'b0, minuend} - {1'b0, subtrahend};
      low = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]};
      diff = full[7:0];
      no_borrow = ~full[8];
      nibble_no_borrow = ~low[4];
      is_zero = (full[7:0] == 8'h00);
   end
endmodule

// ==== hw/siu_core.sv ====
// Subtract instruction unit: APB slave, accumulator, file registers and flags.
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
module siu_core
#(
   parameter int FILE_DEPTH = siu_pkg::SIU_FILE_DEPTH
)
(
   // Clock, reset and clock enable.
   input wire logic CLK,
   input wire logic NRST,
   input wire logic CE,
   // APB slave.
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [siu_pkg::SIU_AW-1:0] PADDR,
   input wire logic [siu_pkg::SIU_DW-1:0] PWDATA,
   output logic [siu_pkg::SIU_DW-1:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // Datapath state seen by the core.
   output logic [7:0] ACC_OUT,
   output logic BORROW_FREE_FLAG,
   output logic NIBBLE_BORROW_FLAG,
   output logic RESULT_NULL_FLAG
);
   import siu_pkg::*;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [SIU_DW-1:0] prdata;
      logic [7:0] acc;
      logic flag_c;
      logic flag_nib;
      logic flag_z;
      logic [SIU_FAW-1:0] ptr;
      logic [SIU_OPW-1:0] last_op;
      logic [FILE_DEPTH-1:0][7:0] mem;
   } siu_state_t;

   siu_state_t st_reg;
   siu_state_t st_next;
   logic access;
   logic commit;
   logic mapped;
   logic [SIU_OPW-1:0] op;
   logic is_lit;
   logic is_reg;
   logic exec_lit;
   logic exec_reg;
   logic dest_file;
   logic [SIU_FAW-1:0] faddr;
   logic [7:0] minuend;
   logic [7:0] sub_diff;
   logic sub_c;
   logic sub_nib;
   logic sub_z;
   logic [SIU_DW-1:0] rd_mux;

   // Decode the bus phase and the opcode carried in the write data.
   always_comb
   begin
      access = CE && PSEL && PENABLE;
      commit = access && st_reg.pready && PWRITE;
      op = PWDATA[SIU_OPW-1:0];
      is_lit = (op[SIU_OPW-1:SIU_OPC_LIT_LSB] == SIU_OPC_LIT);
      is_reg = (op[SIU_OPW-1:SIU_OPC_REG_LSB] == SIU_OPC_REG);
      exec_lit = commit && (PADDR == SIU_OFS_INSTR) && is_lit;
      exec_reg = commit && (PADDR == SIU_OFS_INSTR) && is_reg;
      dest_file = op[SIU_DEST_BIT];
      faddr = op[SIU_FAW-1:0];
      minuend = is_lit ? op[7:0] : st_reg.mem[faddr];
   end

   // The accumulator is always the subtrahend.
   siu_sub u_sub
   (
      .minuend(minuend),
      .subtrahend(st_reg.acc),
      .diff(sub_diff),
      .no_borrow(sub_c),
      .nibble_no_borrow(sub_nib),
      .is_zero(sub_z)
   );

   // Read data and address decode for the register map.
   always_comb
   begin
      rd_mux = '0;
      mapped = 1'b1;
      case (PADDR)
         SIU_OFS_INSTR: rd_mux[SIU_OPW-1:0] = st_reg.last_op;
         SIU_OFS_ACC: rd_mux[7:0] = st_reg.acc;
         SIU_OFS_STATUS:
         begin
            rd_mux[SIU_BIT_C] = st_reg.flag_c;
            rd_mux[SIU_BIT_NIB] = st_reg.flag_nib;
            rd_mux[SIU_BIT_Z] = st_reg.flag_z;
         end
         SIU_OFS_PTR: rd_mux[SIU_FAW-1:0] = st_reg.ptr;
         SIU_OFS_DATA: rd_mux[7:0] = st_reg.mem[st_reg.ptr];
         default: mapped = 1'b0;
      endcase
   end

   // Next state: the answer is prepared in the first access cycle and a write
   // commits on the edge at which the master sees PREADY high.
   always_comb
   begin
      st_next = st_reg;
      if (CE)
      begin
         st_next.pready = 1'b0;
         if (access && !st_reg.pready)
         begin
            st_next.pready = 1'b1;
            st_next.prdata = PWRITE ? '0 : rd_mux;
            st_next.pslverr = !mapped ||
               (PWRITE && (PADDR == SIU_OFS_INSTR) && !is_lit && !is_reg);
         end
         if (commit && !st_reg.pslverr)
         begin
            case (PADDR)
               SIU_OFS_INSTR:
               begin
                  st_next.last_op = op;
                  st_next.flag_c = sub_c;
                  st_next.flag_nib = sub_nib;
                  st_next.flag_z = sub_z;
                  if (is_reg && dest_file)
                  begin
                     st_next.mem[faddr] = sub_diff;
                  end
                  else
                  begin
                     st_next.acc = sub_diff;
                  end
               end
               SIU_OFS_ACC: st_next.acc = PWDATA[7:0];
               SIU_OFS_STATUS:
               begin
                  st_next.flag_c = PWDATA[SIU_BIT_C];
                  st_next.flag_nib = PWDATA[SIU_BIT_NIB];
                  st_next.flag_z = PWDATA[SIU_BIT_Z];
               end
               SIU_OFS_PTR: st_next.ptr = PWDATA[SIU_FAW-1:0];
               SIU_OFS_DATA: st_next.mem[st_reg.ptr] = PWDATA[7:0];
               default: st_next.acc = st_reg.acc;
            endcase
         end
      end
   end

   // State register; the file array clears with the rest.
   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         st_reg.pready <= 1'b0;
         st_reg.pslverr <= 1'b0;
         st_reg.prdata <= '0;
         st_reg.acc <= SIU_ACC_RST;
         st_reg.flag_c <= SIU_FLAG_RST;
         st_reg.flag_nib <= SIU_FLAG_RST;
         st_reg.flag_z <= SIU_FLAG_RST;
         st_reg.ptr <= SIU_PTR_RST;
         st_reg.last_op <= SIU_OP_RST;
         st_reg.mem <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // Outputs come straight from the state register.
   assign PRDATA = st_reg.prdata;
   assign PREADY = st_reg.pready;
   assign PSLVERR = st_reg.pslverr;
   assign ACC_OUT = st_reg.acc;
   assign BORROW_FREE_FLAG = st_reg.flag_c;
   assign NIBBLE_BORROW_FLAG = st_reg.flag_nib;
   assign RESULT_NULL_FLAG = st_reg.flag_z;

   // Named steps of an executed instruction.
   sequence s_lit_exec;
      exec_lit && !st_reg.pslverr;
   endsequence

   sequence s_reg_exec;
      exec_reg && !st_reg.pslverr;
   endsequence

   sequence s_any_exec;
      (exec_lit || exec_reg) && !st_reg.pslverr;
   endsequence

   a_lit_result: assert property (@(posedge CLK) disable iff (!NRST)
      s_lit_exec |=> st_reg.acc == 8'($past(PWDATA[7:0]) - $past(st_reg.acc)))
      else $error("Literal subtract gave a wrong accumulator.");

   a_reg_result: assert property (@(posedge CLK) disable iff (!NRST)
      s_reg_exec |=> ($past(dest_file) ? st_reg.mem[$past(faddr)] : st_reg.acc)
         == 8'($past(st_reg.mem[faddr]) - $past(st_reg.acc)))
      else $error("File subtract gave a wrong difference.");

   a_dest_acc: assert property (@(posedge CLK) disable iff (!NRST)
      s_reg_exec ##0 !dest_file |=> st_reg.mem == $past(st_reg.mem))
      else $error("File changed although the accumulator was the target.");

   a_dest_file: assert property (@(posedge CLK) disable iff (!NRST)
      s_reg_exec ##0 dest_file |=> st_reg.acc == $past(st_reg.acc))
      else $error("Accumulator changed although the file was the target.");

   a_carry_positive: assert property (@(posedge CLK) disable iff (!NRST)
      s_any_exec ##0 (minuend > st_reg.acc) |=> st_reg.flag_c && !st_reg.flag_z)
      else $error("Positive difference did not set the borrow-free flag.");

   a_carry_zero: assert property (@(posedge CLK) disable iff (!NRST)
      s_any_exec ##0 (minuend == st_reg.acc) |=> st_reg.flag_c && st_reg.flag_z)
      else $error("Zero difference did not set borrow-free and zero flags.");

   a_carry_negative: assert property (@(posedge CLK) disable iff (!NRST)
      s_any_exec ##0 (minuend < st_reg.acc) |=> !st_reg.flag_c)
      else $error("Negative difference did not clear the borrow-free flag.");

   a_nibble_flag: assert property (@(posedge CLK) disable iff (!NRST)
      s_any_exec |=> st_reg.flag_nib == ($past(minuend[3:0]) >= $past(st_reg.acc[3:0])))
      else $error("Nibble borrow flag is wrong.");

   a_apb_answer: assert property (@(posedge CLK) disable iff (!NRST)
      CE && PSEL && PENABLE && !PREADY |=> PREADY)
      else $error("Access phase was not answered within one cycle.");

   a_ce_freeze: assert property (@(posedge CLK) disable iff (!NRST)
      !CE |=> $stable(st_reg))
      else $error("State moved while the clock enable was low.");
endmodule

// ==== tb/siu_host.sv ====
// Bus master model of the core decoder that issues register transfers.
`timescale 1ns/100ps
module siu_host
(
   // Clock.
   input wire logic clk,
   // Request.
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   // Answer.
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   // Idle levels from time zero.
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end

   // One transfer; the request is held until pready is seen at an edge, for at most 50 edges.
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd, output logic err, output bit ok);
      ok = 1'b0;
      rd = 32'h0;
      err = 1'b0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      for (int n = 0; n < 50 && !ok; n++)
      begin
         @(posedge clk);
         if (pready === 1'b1)
         begin
            ok = 1'b1;
            rd = prdata;
            err = pslverr;
         end
      end
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~a;
      pwdata <= ~wd;
   endtask
endmodule

// ==== tb/tb_top.sv ====
// Self-checking bench for the subtract instruction unit.
`timescale 1ns/100ps
module tb_top;
   import siu_pkg::*;
   logic clk, nrst, ce, psel, penable, pwrite, pready, pslverr;
   logic [SIU_AW-1:0] paddr;
   logic [SIU_DW-1:0] pwdata, prdata;
   logic [7:0] acc_out;
   logic borrow_free, nibble_ok, null_res;
   int miscompares = 0;
   int cmp_count = 0;

   siu_core i_siu_core (.CLK(clk), .NRST(nrst), .CE(ce), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .ACC_OUT(acc_out), .BORROW_FREE_FLAG(borrow_free),
      .NIBBLE_BORROW_FLAG(nibble_ok), .RESULT_NULL_FLAG(null_res));
   siu_host i_siu_host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

   // Free-running 10 MHz clock.
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         miscompares++;
         $display("mismatch at %0t: got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic wrap_up();
      $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // A transfer that never completes ends the run.
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd, output logic err);
      bit ok;
      i_siu_host.xfer(wr, a, wd, rd, err, ok);
      if (!ok)
      begin
         miscompares++;
         wrap_up();
      end
   endtask

   // Expected {zero, nibble no-borrow, no-borrow, difference} of m minus s.
   function automatic logic [10:0] sub_exp(input logic [7:0] m, input logic [7:0] s);
      logic [7:0] d;
      d = m - s;
      return {d == 8'h00, m[3:0] >= s[3:0], m >= s, d};
   endfunction

   // Loads operands, executes one subtract and checks every result.
   task automatic run_op(input bit lit, input logic [7:0] v, input logic [6:0] f,
      input logic d, input logic [7:0] acc0);
      logic [31:0] rd;
      logic err;
      logic [10:0] e;
      logic [13:0] op;
      e = sub_exp(v, acc0);
      op = lit ? {SIU_OPC_LIT, 1'($urandom), v} : {SIU_OPC_REG, d, f};
      bus(1'b1, SIU_OFS_ACC, {24'h0, acc0}, rd, err);
      bus(1'b1, SIU_OFS_PTR, {25'h0, f}, rd, err);
      bus(1'b1, SIU_OFS_DATA, {24'h0, lit ? ~v : v}, rd, err);
      bus(1'b1, SIU_OFS_INSTR, {18'h0, op}, rd, err);
      chk({31'h0, err}, 32'h0);
      @(negedge clk);
      chk({24'h0, acc_out}, {24'h0, (lit || !d) ? e[7:0] : acc0});
      chk({29'h0, null_res, nibble_ok, borrow_free}, {29'h0, e[10:8]});
      bus(1'b0, SIU_OFS_STATUS, 32'h0, rd, err);
      chk(rd, {29'h0, e[10:8]});
      bus(1'b0, SIU_OFS_INSTR, 32'h0, rd, err);
      chk(rd, {18'h0, op});
      bus(1'b0, SIU_OFS_DATA, 32'h0, rd, err);
      chk(rd, {24'h0, (!lit && d) ? e[7:0] : (lit ? ~v : v)});
   endtask

   // Main sequence: reset, corner cases, random operations, refusals.
   initial
   begin
      logic [31:0] rd;
      logic err;
      nrst = 1'b0;
      ce = 1'b1;
      void'($urandom(32'h9051f8a3));
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      @(negedge clk);
      chk({24'h0, acc_out}, {24'h0, SIU_ACC_RST});
      chk({29'h0, null_res, nibble_ok, borrow_free}, 32'h0);
      for (int i = 1; i <= 3; i++)
      begin
         run_op(1'b1, 8'h02, 7'h05, 1'b0, 8'(i));
         run_op(1'b0, 8'(4 - i), 7'h7F, 1'b1, 8'h02);
      end
      run_op(1'b0, 8'h10, 7'h00, 1'b0, 8'h01);
      $display("test corner done");
      repeat (40) run_op(1'($urandom), 8'($urandom), 7'($urandom), 1'($urandom), 8'($urandom));
      $display("test random done");
      // Reset in mid-run clears the accumulator, the flags, the pointer and the file.
      @(posedge clk);
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      @(negedge clk);
      chk({24'h0, acc_out}, {24'h0, SIU_ACC_RST});
      chk({29'h0, null_res, nibble_ok, borrow_free}, 32'h0);
      bus(1'b0, SIU_OFS_PTR, 32'h0, rd, err);
      chk(rd, 32'h0);
      bus(1'b0, SIU_OFS_DATA, 32'h0, rd, err);
      chk(rd, 32'h0);
      $display("test reset done");
      // Clock enable low in mid-transfer stalls the answer and freezes all state.
      fork
         bus(1'b1, SIU_OFS_ACC, 32'h0000005A, rd, err);
         begin
            repeat (2) @(posedge clk);
            ce <= 1'b0;
            repeat (4) @(posedge clk);
            chk({31'h0, pready}, 32'h0);
            chk({24'h0, acc_out}, {24'h0, SIU_ACC_RST});
            ce <= 1'b1;
         end
      join
      @(negedge clk);
      chk({24'h0, acc_out}, 32'h0000005A);
      bus(1'b0, SIU_OFS_ACC, 32'h0, rd, err);
      chk(rd, 32'h0000005A);
      bus(1'b1, SIU_OFS_STATUS, 32'h00000005, rd, err);
      @(negedge clk);
      chk({29'h0, null_res, nibble_ok, borrow_free}, 32'h00000005);
      $display("test enable done");
      bus(1'b0, 8'h14, 32'h0, rd, err);
      chk({31'h0, err}, 32'h1);
      chk(rd, 32'h0);
      bus(1'b1, SIU_OFS_INSTR, 32'h0, rd, err);
      chk({31'h0, err}, 32'h1);
      @(negedge clk);
      chk({24'h0, acc_out}, 32'h0000005A);
      chk({29'h0, null_res, nibble_ok, borrow_free}, 32'h00000005);
      $display("test refusals done");
      wrap_up();
   end
endmodule
